// >>> logic/imdy_consts.svh
// Purpose: Shared constants of the interleaved memory with debug yield.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef IMDY_CONSTS_SVH
`define IMDY_CONSTS_SVH

// Access option code that hands the buses to the development system.
`define IMDY_OPT_TAKEOVER 3'h6
// Access option code used for plain memory reads and writes by the processor.
`define IMDY_OPT_NORMAL   3'h0
// System clock period in ns (200 MHz).
`define IMDY_CLK_NS       5
// Least time before an access to an unmapped address ends in error, in ns.
`define IMDY_TIMEOUT_NS   200
// Timeout in cycles, rounded up to whole cycles.
`define IMDY_TIMEOUT_CYC  ((`IMDY_TIMEOUT_NS + `IMDY_CLK_NS - 1) / `IMDY_CLK_NS)
// Width of the timeout counter.
`define IMDY_TO_W         16
// Bank count and bank select bit of the word address.
`define IMDY_BANKS        2
`define IMDY_BANK_BIT     0

`endif

// >>> logic/imdy_pkg.sv
// Purpose: Types shared by the interleaved memory controller files.
// Assumes: Word addressed 30-bit address, as on a 32-bit byte bus.
// Notes:   Holds types only; numbers live in imdy_consts.svh.
`default_nettype none
package imdy_pkg;

  // One processor request, presented for a single cycle.
  typedef struct packed {
    logic        valid;     // Request present this cycle.
    logic        isInstr;   // Instruction fetch rather than data access.
    logic        isWrite;   // Store (data side only).
    logic        burst;     // Next sequential word of the running burst.
    logic        loadStore; // Access comes from a load or store.
    logic [2:0]  option;    // Access option code, bit 0 is the LSB.
    logic [29:0] addr;      // Word address, used when burst is low.
  } imdy_req_t;

  // Controller states.
  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_TIMEOUT} imdy_state_t;

endpackage : imdy_pkg
`default_nettype wire

// >>> logic/imdy_bank.sv
// Purpose: One memory bank with a two-cycle access pipeline.
// Assumes: Start pulses for one bank never come in two adjacent cycles.
// Notes:   Read data is a flop, valid two cycles after the start.
`timescale 1ns/1ps
`default_nettype none
module imdy_bank #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst,
  // Access start.
  input  wire logic          start,
  input  wire logic          write,
  input  wire logic [AW-1:0] idx,
  input  wire logic [DW-1:0] wdata,
  // Read result.
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(2**AW)-1]; // Word storage in flops.
  logic          s1Go;              // Access in its first cycle.
  logic          s1Write;           // Held write flag.
  logic [AW-1:0] s1Idx;             // Held word index.
  logic [DW-1:0] s1Data;            // Held write data.

  // First cycle: address and data are held, giving the array two cycles.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1Go    <= 1'b0;
      s1Write <= 1'b0;
      s1Idx   <= '0;
      s1Data  <= '0;
    end else begin
      s1Go    <= start;
      s1Write <= write;
      s1Idx   <= idx;
      s1Data  <= wdata;
    end
  end

  // Second cycle: the array completes the read or the write.
  always_ff @(posedge clk) begin
    if (s1Go && s1Write) begin
      mem[s1Idx] <= s1Data;
    end
  end

  // Read data stays until the next read of this bank.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (s1Go && !s1Write) begin
      rdata <= mem[s1Idx];
    end
  end

endmodule : imdy_bank
`default_nettype wire

// >>> logic/imdy_ctrl.sv
// Purpose: Two-bank interleaved memory that yields its buses to a debug tool.
// Assumes: Requests are synchronous to clk; the bus pads resolve the enables.
// Notes:   Responses come two cycles after a request; bursts stream one word
//          per cycle after that.
`timescale 1ns/1ps
`default_nettype none
`include "imdy_consts.svh"

// Overview of operation
// - Even words in bank zero, odd in one.
// - Banks start alternately, each gets two cycles.
// - First word two cycles, burst words single.
// - Single-bank chip enable follows the system clock.
// - Locator pin low disables all memory selection.
// - Option 110 on load/store yields buses.
// - Option bit 0 is the least significant.
// - During takeover no response, no bus drive.
// - Ready/error released on pin low or 110.
// - Pin high means normal memory response.
// - Instruction memory reachable over the data bus.
// - Drive data only while asserting ready.
// - Unmapped access ends in error after timeout.
module imdy_ctrl #(
  parameter int MEM_AW      = 9,
  parameter int TIMEOUT_CYC = `IMDY_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // Processor request and takeover pin (high in normal operation).
  input  wire imdy_pkg::imdy_req_t req,
  input  wire logic                locatorPin,
  // Instruction bus.
  input  wire logic [31:0]         instrBusIn,
  output logic      [31:0]         instrBusOut,
  output logic                     instrBusOe,
  // Data bus.
  input  wire logic [31:0]         dataBusIn,
  output logic      [31:0]         dataBusOut,
  output logic                     dataBusOe,
  // Open-drain response lines, active low.
  input  wire logic                dataReadyResponseNIn,
  output logic                     dataReadyResponseNOut,
  output logic                     dataReadyResponseOe,
  input  wire logic                dataErrorResponseNIn,
  output logic                     dataErrorResponseNOut,
  output logic                     dataErrorResponseOe,
  // Clock-gated chip enable for a single fast bank, active low.
  output logic                     chipEnableN
);

  localparam int TO_MAX = TIMEOUT_CYC + 1; // Request to error response.

  // ****************************************************************
  // Request decode and takeover
  // ****************************************************************

  imdy_pkg::imdy_state_t state;           // Controller state.
  logic [29:0]           lastAddr;        // Word address of the last issue.
  logic                  burstInstr;      // Running burst is a fetch.
  logic                  burstWrite;      // Running burst is a store.
  logic [`IMDY_TO_W-1:0] toCount;         // Cycles left before error.
  logic                  optTake;         // Reserved option code seen.
  logic                  takeover;        // Development system owns buses.
  logic                  newAcc;          // Non-sequential request.
  logic                  contAcc;         // Sequential burst request.
  logic                  issue;           // Request accepted by memory.
  logic                  mapped;          // Address lies in this memory.
  logic                  go;              // Banks are started.
  logic [29:0]           issueAddr;       // Address being started.
  logic                  issueInstr;      // Started access is a fetch.
  logic                  issueWrite;      // Started access is a store.
  logic                  s1Valid;         // Access in its first cycle.
  logic                  s1Instr;
  logic                  s1Write;
  logic                  s1Bank;
  logic                  rspValid;        // Access answers this cycle.
  logic                  rspInstr;
  logic                  rspWrite;
  logic                  rspBank;
  logic                  errFlag;         // Timeout error answers now.
  logic                  chipSel;         // Single-bank select, per cycle.
  logic [31:0]           bankRd [`IMDY_BANKS]; // Bank read data flops.

  // Option code is compared as a whole field, bit 0 at the right.
  assign optTake  = req.valid && req.loadStore
                    && (req.option == `IMDY_OPT_TAKEOVER);
  // Either indication alone hands the buses over.
  assign takeover = !locatorPin || optTake;

  assign newAcc  = req.valid && !req.burst && (state != imdy_pkg::ST_TIMEOUT);
  assign contAcc = req.valid && req.burst && (state == imdy_pkg::ST_BURST);
  // Selection is disabled outright while the tool has the buses.
  assign issue   = (newAcc || contAcc) && !takeover;
  // A burst continues from the last word, so each word alternates bank.
  assign issueAddr  = newAcc ? req.addr : 30'(lastAddr + 30'h1);
  assign issueInstr = newAcc ? req.isInstr : burstInstr;
  // Fetches never write; stores reach both code and data over the data bus.
  assign issueWrite = newAcc ? (req.isWrite && !req.isInstr) : burstWrite;
  assign mapped = ((issueAddr >> MEM_AW) == 30'h0);
  assign go     = issue && mapped;

  // ****************************************************************
  // Control state
  // ****************************************************************

  // Burst stays open while sequential requests keep coming every cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= imdy_pkg::ST_IDLE;
    end else begin
      case (state)
        imdy_pkg::ST_IDLE, imdy_pkg::ST_BURST: begin
          if (issue && !mapped) begin
            state <= imdy_pkg::ST_TIMEOUT;
          end else if (go) begin
            state <= imdy_pkg::ST_BURST;
          end else begin
            state <= imdy_pkg::ST_IDLE;
          end
        end
        imdy_pkg::ST_TIMEOUT: begin
          if (toCount == '0) begin
            state <= imdy_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= imdy_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Burst address and attributes are kept for the next sequential word.
  always_ff @(posedge clk) begin
    if (rst) begin
      lastAddr   <= 30'h0;
      burstInstr <= 1'b0;
      burstWrite <= 1'b0;
    end else if (go) begin
      lastAddr   <= issueAddr;
      burstInstr <= issueInstr;
      burstWrite <= issueWrite;
    end
  end

  // Nobody answers an unmapped address, so the wait is bounded here.
  always_ff @(posedge clk) begin
    if (rst) begin
      toCount <= '0;
      errFlag <= 1'b0;
    end else begin
      if (issue && !mapped && (state != imdy_pkg::ST_TIMEOUT)) begin
        toCount <= `IMDY_TO_W'(TIMEOUT_CYC - 1);
      end else if (toCount != '0) begin
        toCount <= toCount - `IMDY_TO_W'(1);
      end
      errFlag <= (state == imdy_pkg::ST_TIMEOUT) && (toCount == '0);
    end
  end

  // ****************************************************************
  // Banks and response pipeline
  // ****************************************************************

  // Address bit 0 picks the bank: even words in 0, odd words in 1.
  for (genvar b = 0; b < `IMDY_BANKS; b++) begin : g_bank
    imdy_bank #(
      .AW (MEM_AW - 1),
      .DW (32)
    ) u_bank (
      .clk   (clk),
      .rst   (rst),
      .start (go && (issueAddr[`IMDY_BANK_BIT] == 1'(b))),
      .write (issueWrite),
      .idx   (issueAddr[MEM_AW-1:1]),
      .wdata (dataBusIn),
      .rdata (bankRd[b])
    );
  end

  // Two-stage tag pipe matches the bank latency; bursts overlap in it.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1Valid  <= 1'b0;
      s1Instr  <= 1'b0;
      s1Write  <= 1'b0;
      s1Bank   <= 1'b0;
      rspValid <= 1'b0;
      rspInstr <= 1'b0;
      rspWrite <= 1'b0;
      rspBank  <= 1'b0;
    end else begin
      s1Valid  <= go;
      s1Instr  <= issueInstr;
      s1Write  <= issueWrite;
      s1Bank   <= issueAddr[`IMDY_BANK_BIT];
      rspValid <= s1Valid;
      rspInstr <= s1Instr;
      rspWrite <= s1Write;
      rspBank  <= s1Bank;
    end
  end

  // Chip select for a single fast bank is qualified by the clock low half,
  // so the array never drives or writes across a clock edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      chipSel <= 1'b0;
    end else begin
      chipSel <= go;
    end
  end
  assign chipEnableN = clk || !chipSel;

  // ****************************************************************
  // Bus drivers
  // ****************************************************************

  // Ready and error pull low only when owned; released on any takeover.
  assign dataReadyResponseNOut = 1'b0;
  assign dataErrorResponseNOut = 1'b0;
  assign dataReadyResponseOe   = rspValid && !takeover;
  assign dataErrorResponseOe   = errFlag && !takeover;
  // Bus data is driven only beside our own ready.
  assign dataBusOe   = rspValid && !rspInstr && !rspWrite && !takeover;
  assign instrBusOe  = rspValid && rspInstr && !takeover;
  assign dataBusOut  = bankRd[rspBank];
  assign instrBusOut = bankRd[rspBank];

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_takeover_quiet: assert property (takeover |-> !dataReadyResponseOe
      && !dataErrorResponseOe && !dataBusOe && !instrBusOe)
    else $error("Memory drives a line during takeover.");
  a_opt_decode: assert property (req.valid && req.loadStore && !req.option[0]
      && (req.option[2:1] == 2'b11) |-> !issue)
    else $error("Reserved option code did not block the access.");
  a_pin_blocks: assert property (!locatorPin |-> !go ##1 !s1Valid)
    else $error("Selection active while locator pin is low.");
  a_even_odd: assert property (go |=> (s1Bank == $past(issueAddr[0])))
    else $error("Word went to the wrong bank.");
  // An earlier burst may still be answering, so only the word's own slot is judged.
  a_first_latency: assert property (go && newAcc |=> s1Valid ##1 (rspValid
      && (rspBank == $past(issueAddr[`IMDY_BANK_BIT], 2))))
    else $error("First word not answered after two cycles.");
  a_bank_alternate: assert property (go && contAcc |->
      (issueAddr[0] != lastAddr[0]) ##2 rspValid)
    else $error("Burst word not on the other bank in one cycle.");
  a_drive_ready: assert property ((dataBusOe || instrBusOe) |-> dataReadyResponseOe)
    else $error("Bus driven without ready.");
  a_normal_reply: assert property (rspValid && locatorPin && !optTake
      |-> dataReadyResponseOe)
    else $error("No answer while locator pin is high.");
  a_data_path_code: assert property (rspValid && rspInstr |-> !rspWrite)
    else $error("Fetch turned into a write.");
  a_timeout_err: assert property (issue && !mapped && (state != imdy_pkg::ST_TIMEOUT)
      |-> ##[1:TO_MAX] errFlag)
    else $error("Unmapped access not ended by an error.");

  c_burst_three: cover property (go && newAcc ##1 (go && contAcc) [*2]);
  c_pin_takeover: cover property (!locatorPin && !instrBusOe && (instrBusIn != 32'h0));
  c_tool_reply: cover property (optTake && (!dataReadyResponseNIn || !dataErrorResponseNIn));
  c_timeout: cover property (dataErrorResponseOe);

endmodule : imdy_ctrl
`default_nettype wire

// >>> verif/imdy_tool_model.sv
// Purpose: Far side of the memory: processor bus pads, pull-ups and the debug tool.
// Assumes: An enable high means the memory drives; response lines have pull-ups.
// Notes:   A released bus shows a pattern that flips every cycle, never stale data.
`timescale 1ns/1ps
`default_nettype none
module imdy_tool_model (
  // Clock.
  input  wire logic        clk,
  // Memory side of the pads.
  input  wire logic [31:0] memData,
  input  wire logic        memDataOe,
  input  wire logic [31:0] memInstr,
  input  wire logic        memInstrOe,
  input  wire logic        rdyNOut,
  input  wire logic        rdyOe,
  input  wire logic        errNOut,
  input  wire logic        errOe,
  // Processor store data and the tool's own ready strobe.
  input  wire logic [31:0] procData,
  input  wire logic        procDataEn,
  input  wire logic        toolAnswer,
  // Resolved wire levels.
  output logic      [31:0] dataBus,
  output logic      [31:0] instrBus,
  output logic             rdyN,
  output logic             errN
);
  // Filler for released buses, so the simulator never settles them for us.
  logic [31:0] pattern = 32'h5A5AA5A5;
  always @(posedge clk) pattern <= ~pattern;
  // The memory wins while it answers; otherwise store data or the filler.
  assign dataBus  = memDataOe ? memData : (procDataEn ? procData : pattern);
  assign instrBus = memInstrOe ? memInstr : ~pattern;
  // Open-drain lines; the tool pulls ready itself while toolAnswer is high.
  assign rdyN = ((rdyOe && !rdyNOut) || toolAnswer) ? 1'h0 : 1'h1;
  assign errN = (errOe && !errNOut) ? 1'h0 : 1'h1;
endmodule : imdy_tool_model
`default_nettype wire

// >>> verif/imdy_ctrl_tb_top.sv
// Purpose: Self-checking bench for the interleaved memory with debug yield.
// Assumes: Inputs change at the falling edge; answers come two cycles after a request.
// Notes:   A short timeout parameter keeps the unmapped case brief.
`timescale 1ns/1ps
`default_nettype none
module imdy_ctrl_tb_top;
  // Expected outputs of one cycle.
  typedef struct packed {
    logic        rdy;
    logic        dOe;
    logic        iOe;
    logic        err;
    logic [31:0] data;
  } imdy_exp_t;
  localparam int        TO   = 4;  // Shortened timeout in cycles.
  localparam imdy_exp_t NONE = '0;
  localparam imdy_exp_t ERR  = '{1'h0, 1'h0, 1'h0, 1'h1, 32'h0};
  logic                clk = 1'h0;
  logic                rst = 1'h1;
  imdy_pkg::imdy_req_t req = '0;
  logic                loc = 1'h1;
  logic [31:0]         procData = 32'h0;
  logic                procEn = 1'h0;
  logic                toolAns = 1'h0;
  wire logic [31:0]    iOut, dOut, iBus, dBus;
  wire logic           iOe, dOe, rNOut, rOe, eNOut, eOe, ceN, rdyN, errN;
  imdy_exp_t           expArr [0:1023];  // Answer expected in each cycle number.
  int                  n = 0;
  int                  errors = 0;
  int                  n_compared = 0;

  always #2.5 clk = ~clk;

  imdy_ctrl #(.MEM_AW(9), .TIMEOUT_CYC(TO)) DUT (
    .clk(clk), .rst(rst), .req(req), .locatorPin(loc),
    .instrBusIn(iBus), .instrBusOut(iOut), .instrBusOe(iOe),
    .dataBusIn(dBus), .dataBusOut(dOut), .dataBusOe(dOe),
    .dataReadyResponseNIn(rdyN), .dataReadyResponseNOut(rNOut), .dataReadyResponseOe(rOe),
    .dataErrorResponseNIn(errN), .dataErrorResponseNOut(eNOut), .dataErrorResponseOe(eOe),
    .chipEnableN(ceN));

  imdy_tool_model far (
    .clk(clk), .memData(dOut), .memDataOe(dOe), .memInstr(iOut), .memInstrOe(iOe),
    .rdyNOut(rNOut), .rdyOe(rOe), .errNOut(eNOut), .errOe(eOe), .procData(procData),
    .procDataEn(procEn), .toolAnswer(toolAns), .dataBus(dBus), .instrBus(iBus),
    .rdyN(rdyN), .errN(errN));

  // ****************************************
  // Shared helpers
  // ****************************************
  // Count a comparison and report a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  // Flags are instr, write, burst, load/store from the top bit down.
  function automatic imdy_pkg::imdy_req_t mk(input logic [3:0] f, input logic [2:0] o,
                                             input int a);
    mk = '{1'h1, f[3], f[2], f[1], f[0], o, 30'(a)};
  endfunction : mk

  // Word contents are a function of the address, so a bank swap shows.
  function automatic logic [31:0] val(input int a);
    val = {16'hC3A5, a[15:0]};
  endfunction : val

  function automatic imdy_exp_t rd(input logic instr, input logic [31:0] d);
    rd = '{1'h1, !instr, instr, 1'h0, d};
  endfunction : rd

  function automatic imdy_exp_t wr(input logic [31:0] d);
    wr = '{1'h1, 1'h0, 1'h0, 1'h0, d};
  endfunction : wr

  // One cycle: present a request, book its answer, judge this cycle's outputs.
  task automatic cyc(input imdy_pkg::imdy_req_t r, input logic l, input int lat,
                     input imdy_exp_t e);
    imdy_exp_t w;
    @(negedge clk);
    req = r;
    loc = l;
    procEn = r.valid & r.isWrite;
    procData = e.data;
    toolAns = r.valid & r.loadStore & (r.option == 3'h6);
    if (e.rdy | e.err) expArr[n + lat] = e;
    w = expArr[n];
    // A takeover silences the memory in the very cycle it shows.
    if (!l || toolAns) w = NONE;
    #2;
    check(rOe, w.rdy, "ready");
    check(dOe, w.dOe, "data enable");
    check(iOe, w.iOe, "instr enable");
    check(eOe, w.err, "error");
    check(rdyN, !(w.rdy | toolAns), "ready wire");
    check(errN, !w.err, "error wire");
    if (w.dOe) check(dOut, w.data, "data word");
    if (w.iOe) check(iOut, w.data, "instr word");
    n++;
  endtask : cyc

  task automatic idle(input int k);
    repeat (k) cyc('0, 1'h1, 2, NONE);
  endtask : idle

  // ****************************************
  // Scenarios
  // ****************************************
  // A write burst, then read bursts from an even and an odd start.
  task automatic t_burst;
    for (int i = 0; i < 6; i++) begin
      cyc(mk(i ? 4'h7 : 4'h5, 3'h0, 16 + i), 1'h1, 2, wr(val(16 + i)));
    end
    for (int i = 0; i < 6; i++) begin
      cyc(mk(i ? 4'h3 : 4'h1, 3'h0, 16), 1'h1, 2, rd(1'h0, val(16 + i)));
    end
    for (int i = 0; i < 3; i++) begin
      cyc(mk(i ? 4'h3 : 4'h1, 3'h0, 17), 1'h1, 2, rd(1'h0, val(17 + i)));
    end
    // One gap closes the burst, so a later continuation has nothing to follow.
    idle(1);
    cyc(mk(4'h3, 3'h0, 16), 1'h1, 2, NONE);
    idle(3);
    $display("t_burst done");
  endtask : t_burst

  // Program words go in over the data bus and come back as a fetch burst.
  task automatic t_fetch;
    cyc(mk(4'h5, 3'h0, 32), 1'h1, 2, wr(val(32)));
    cyc(mk(4'h5, 3'h0, 33), 1'h1, 2, wr(val(33)));
    // Code 110 outside a load or store must not yield the buses.
    for (int i = 0; i < 2; i++) begin
      cyc(mk(i ? 4'hA : 4'h8, 3'h6, 32), 1'h1, 2, rd(1'h1, val(32 + i)));
    end
    idle(3);
    $display("t_fetch done");
  endtask : t_fetch

  // Every option code on a load; only 110 hands the buses to the tool.
  task automatic t_options;
    for (int o = 0; o < 8; o++) begin
      cyc(mk(4'h1, 3'(o), 16 + o % 6), 1'h1, 2,
          o == 6 ? NONE : rd(1'h0, val(16 + o % 6)));
      idle(2);
    end
    $display("t_options done");
  endtask : t_options

  // Pin low kills an answer in flight and blocks new requests.
  task automatic t_locator;
    cyc(mk(4'h1, 3'h0, 18), 1'h1, 2, rd(1'h0, val(18)));
    idle(1);
    cyc('0, 1'h0, 2, NONE);
    cyc(mk(4'h1, 3'h0, 19), 1'h0, 2, NONE);
    idle(3);
    cyc(mk(4'h5, 3'h0, 20), 1'h1, 2, wr(val(20)));
    idle(3);
    $display("t_locator done");
  endtask : t_locator

  // Unmapped address ends in error; requests meanwhile are refused.
  task automatic t_timeout;
    cyc(mk(4'h1, 3'h0, 512), 1'h1, TO + 1, ERR);
    idle(1);
    cyc(mk(4'h1, 3'h0, 16), 1'h1, 2, NONE);
    idle(TO - 2);
    cyc(mk(4'h1, 3'h0, 17), 1'h1, 2, rd(1'h0, val(17)));
    idle(3);
    $display("t_timeout done");
  endtask : t_timeout

  // The chip enable strobes only in the low clock half of the cycle after a bank start.
  task automatic t_chip;
    for (int i = 0; i < 4; i++) begin
      cyc(mk(i ? 4'h3 : 4'h1, 3'h0, 16), 1'h1, 2, rd(1'h0, val(16 + i)));
      if (i == 3) check(ceN, 1'h0, "enable low half");
    end
    @(posedge clk);
    #1;
    check(ceN, 1'h1, "enable high half");
    idle(6);
    check(ceN, 1'h1, "enable idle");
    $display("t_chip done");
  endtask : t_chip

  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence after five reset cycles.
  initial begin
    foreach (expArr[i]) expArr[i] = NONE;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    t_burst();
    t_fetch();
    t_options();
    t_locator();
    t_timeout();
    t_chip();
    tally_and_finish();
  end

  // About 85 cycles are expected; this waits some sixty times longer.
  initial begin
    #25000;
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : imdy_ctrl_tb_top
`default_nettype wire
